/* ass_pkg.sv */
// constants, register map and state types of the sweep sequencer.
// assumes one core clock; the register bus is a plain strobe port.
package ass_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [7:0] OFS_CTRL_0 = 8'h00;
    localparam logic [7:0] OFS_CTRL_1 = 8'h04;
    localparam logic [7:0] OFS_CTRL_2 = 8'h08;
    localparam logic [7:0] OFS_CTRL_3 = 8'h0c;
    localparam logic [7:0] OFS_CTRL_4 = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_SLOT_BASE = 8'h20;
    localparam logic [7:0] OFS_SLOT_LAST = 8'h3c;

    ////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int CTRL0_MODE_SEL_B0 = 0;
    localparam int CTRL0_MODE_SEL_B1 = 1;
    localparam int CTRL0_TRIGGER_SOURCE_SEL = 2;
    localparam int CTRL0_CONV_START_BIT = 3;
    localparam int CTRL1_SWEEP_COUNT_LO = 0;
    localparam int CTRL1_SWEEP_COUNT_HI = 1;
    localparam int CTRL1_MODE_SEL_B2 = 2;
    localparam int CTRL1_RES_10BIT = 3;
    localparam int CTRL2_INPUT_GROUP_LO = 0;
    localparam int CTRL2_INPUT_GROUP_HI = 1;
    localparam int CTRL2_HW_TRIGGER_SEL = 2;
    localparam int CTRL3_DMA_MODE_USE = 0;
    localparam int CTRL3_MULTIPORT_SWEEP_EN = 1;
    localparam int CTRL4_MULTIPORT_SEL_LO = 0;
    localparam int CTRL4_MULTIPORT_SEL_HI = 1;

    ////////////////////////////////////////////////////////////////////////////
    // reset values and sequence figures
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [9:0] SLOT_RESET = 10'h000;
    localparam logic [3:0] MP_LAST_STEP = 4'hf;
    localparam logic [2:0] PIN_LAST = 3'h7;
    localparam logic [1:0] FIRST_GROUP = 2'h0;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ARMED = 2'b01,
        ST_REQ = 2'b10,
        ST_WAIT = 2'b11
    } ass_state_type;

    typedef enum logic [2:0] {
        MODE_NONE = 3'b000,
        MODE_SS = 3'b001,
        MODE_RS0 = 3'b010,
        MODE_RS1 = 3'b011,
        MODE_MPSS = 3'b100,
        MODE_MPRS = 3'b101
    } ass_mode_type;

endpackage : ass_pkg

/* ass_sweep_sequencer.sv */
// sweep sequencer: register file, trigger selection, pin order, result slots.
// assumes an external converter core that accepts a start pulse with a
// channel and answers later with a done pulse and a 10-bit code.
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - repeat sweep 0 converts 2, 4, 6 or 8 inputs and restarts endlessly
// - sweep width from sweep-count field, group from group field, inputs from 0
// - software trigger: start as soon as start bit is written 1
// - external trigger: falling edge of trigger input after start bit set
// - hardware trigger: motor timer count-complete request after start bit set
// - repeat modes run until software clears the start bit
// - repeat sweeps 0 and 1: no request without dma mode, one per conversion with it
// - without dma mode each result lands in the slot of its input
// - with dma mode every result lands in slot zero for the dma
// - repeat sweep 1 converts all eight inputs, giving prioritised inputs extra turns
// - repeat sweep 1 has 1 to 4 prioritised inputs starting at input 0
// - repeat sweep 1 ignores trigger edges once conversion has started
// - multi-port single sweep: 16 inputs, first group then second, ascending
// - single sweeps stop after last conversion, clearing start bit on software trigger
// - multi-port repeat sweep cycles the 16-input order until start bit cleared
// - multi-port arrangement comes from the two-bit select field in control 4
// - multi-port modes request an interrupt after every conversion
// - resolution bit 1 gives 10-bit results in bits 9 to 0
// - resolution bit 0 gives 8-bit results in bits 7 to 0
// - five modes decoded from three mode bits and the multi-port bit
// - a trigger during conversion aborts and restarts unless retrigger is invalid
module ass_sweep_sequencer #(
    parameter int RESULT_W = 10,
    parameter int NUM_SLOTS = 8
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic [7:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rdata,
    input wire logic i_ext_trigger_in_n,
    input wire logic i_motor_timer_count,
    output logic o_conv_start,
    output logic [4:0] o_conv_channel,
    output logic o_conv_10bit,
    input wire logic i_conv_done,
    input wire logic [9:0] i_conv_data,
    output logic o_done_strobe,
    output logic o_irq,
    output logic o_dma_req,
    output logic [9:0] o_result,
    output logic [9:0] o_result_slot_zero
);
    import ass_pkg::*;

    if (RESULT_W != 10 || NUM_SLOTS != 8) begin : g_param_check
        $error("ass_sweep_sequencer supports only 10-bit results and 8 slots");
    end

    ////////////////////////////////////////////////////////////////////////////
    // control registers
    logic [7:0] conv_ctrl_0;
    logic [7:0] conv_ctrl_1;
    logic [7:0] conv_ctrl_2;
    logic [7:0] conv_ctrl_3;
    logic [7:0] conv_ctrl_4;
    logic hw_clear_start;
    logic wr_ctrl0;
    assign wr_ctrl0 = i_wr && (i_addr == OFS_CTRL_0);

    // a software write in the same cycle as the hardware stop wins, so a fresh start
    // written at the end of a pass keeps the start bit set, but the sequencer waits in ST_ARMED for a trigger edge
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            conv_ctrl_0 <= CTRL_RESET;
        end else if (wr_ctrl0) begin
            conv_ctrl_0 <= i_wdata[7:0];
        end else if (hw_clear_start) begin
            conv_ctrl_0[CTRL0_CONV_START_BIT] <= 1'b0;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            conv_ctrl_1 <= CTRL_RESET;
            conv_ctrl_2 <= CTRL_RESET;
            conv_ctrl_3 <= CTRL_RESET;
            conv_ctrl_4 <= CTRL_RESET;
        end else if (i_wr) begin
            if (i_addr == OFS_CTRL_1) begin
                conv_ctrl_1 <= i_wdata[7:0];
            end
            if (i_addr == OFS_CTRL_2) begin
                conv_ctrl_2 <= i_wdata[7:0];
            end
            if (i_addr == OFS_CTRL_3) begin
                conv_ctrl_3 <= i_wdata[7:0];
            end
            if (i_addr == OFS_CTRL_4) begin
                conv_ctrl_4 <= i_wdata[7:0];
            end
        end
    end

    logic conv_start_bit;
    logic trigger_source_sel;
    logic hw_trigger_sel;
    logic dma_mode_use;
    logic res_10bit;
    logic [1:0] sweep_count;
    logic [1:0] input_group;
    logic [1:0] multiport_sel;
    logic [2:0] mode_bits;
    logic multiport_sweep_en;
    assign conv_start_bit = conv_ctrl_0[CTRL0_CONV_START_BIT];
    assign trigger_source_sel = conv_ctrl_0[CTRL0_TRIGGER_SOURCE_SEL];
    assign hw_trigger_sel = conv_ctrl_2[CTRL2_HW_TRIGGER_SEL];
    assign dma_mode_use = conv_ctrl_3[CTRL3_DMA_MODE_USE];
    assign multiport_sweep_en = conv_ctrl_3[CTRL3_MULTIPORT_SWEEP_EN];
    assign res_10bit = conv_ctrl_1[CTRL1_RES_10BIT];
    assign sweep_count = {conv_ctrl_1[CTRL1_SWEEP_COUNT_HI], conv_ctrl_1[CTRL1_SWEEP_COUNT_LO]};
    assign input_group = {conv_ctrl_2[CTRL2_INPUT_GROUP_HI], conv_ctrl_2[CTRL2_INPUT_GROUP_LO]};
    assign multiport_sel = {conv_ctrl_4[CTRL4_MULTIPORT_SEL_HI], conv_ctrl_4[CTRL4_MULTIPORT_SEL_LO]};
    assign mode_bits = {conv_ctrl_1[CTRL1_MODE_SEL_B2], conv_ctrl_0[CTRL0_MODE_SEL_B1],
                        conv_ctrl_0[CTRL0_MODE_SEL_B0]};

    ////////////////////////////////////////////////////////////////////////////
    // mode decode; one-shot and repeat are not served here and sit idle
    ass_mode_type mode;
    always_comb begin
        mode = MODE_NONE;
        if (!multiport_sweep_en) begin
            if (mode_bits == 3'h2) begin
                mode = MODE_SS;
            end else if (mode_bits == 3'h3) begin
                mode = MODE_RS0;
            end else if (mode_bits == 3'h7) begin
                mode = MODE_RS1;
            end
        end else if (mode_bits == 3'h2) begin
            mode = MODE_MPSS;
        end else if (mode_bits == 3'h3) begin
            mode = MODE_MPRS;
        end
    end

    logic mode_ok;
    logic mode_mp;
    logic mode_single;
    assign mode_ok = (mode != MODE_NONE);
    assign mode_mp = (mode == MODE_MPSS) || (mode == MODE_MPRS);
    assign mode_single = (mode == MODE_SS) || (mode == MODE_MPSS);

    ////////////////////////////////////////////////////////////////////////////
    // trigger events; inputs are synchronous, so a plain previous-value edge
    logic ext_prev;
    logic motor_prev;

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ext_prev <= 1'b1;
            motor_prev <= 1'b0;
        end else begin
            ext_prev <= i_ext_trigger_in_n;
            motor_prev <= i_motor_timer_count;
        end
    end

    logic ext_fall;
    logic motor_rise;
    logic trig_evt;
    assign ext_fall = ext_prev && !i_ext_trigger_in_n;
    assign motor_rise = i_motor_timer_count && !motor_prev;
    assign trig_evt = trigger_source_sel && (hw_trigger_sel ? motor_rise : ext_fall);

    ////////////////////////////////////////////////////////////////////////////
    // pin order
    ass_state_type state;
    logic [3:0] step;
    logic [2:0] rr_pin;
    logic [3:0] prio_n;
    logic [2:0] cur_pin;
    logic [1:0] cur_group;
    logic last_step;
    logic prio_end;
    assign prio_n = {2'b00, sweep_count} + 4'h1;
    assign prio_end = (step == prio_n);

    always_comb begin
        cur_pin = step[2:0];
        cur_group = input_group;
        last_step = (step == {1'b0, sweep_count, 1'b1});
        if (mode == MODE_RS1) begin
            cur_pin = prio_end ? rr_pin : step[2:0];
            last_step = 1'b0;
        end else if (mode_mp) begin
            cur_group = step[3] ? multiport_sel : FIRST_GROUP;
            last_step = (step == MP_LAST_STEP);
        end
    end

    logic retrig;
    logic accept;
    // retrigger is declared invalid only in repeat sweep 1
    assign retrig = (state == ST_WAIT) && trig_evt && (mode != MODE_RS1);
    assign accept = (state == ST_WAIT) && i_conv_done && !retrig;
    assign hw_clear_start = accept && last_step && mode_single && !trigger_source_sel;

    ////////////////////////////////////////////////////////////////////////////
    // sequencer
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= ST_IDLE;
            step <= 4'h0;
            rr_pin <= 3'h0;
            o_conv_start <= 1'b0;
            o_conv_channel <= 5'h00;
        end else begin
            o_conv_start <= 1'b0;
            if (!conv_start_bit || !mode_ok) begin
                state <= ST_IDLE;
                step <= 4'h0;
            end else begin
                unique case (state)
                    ST_IDLE: begin
                        step <= 4'h0;
                        rr_pin <= prio_n[2:0];
                        state <= trigger_source_sel ? ST_ARMED : ST_REQ;
                    end
                    ST_ARMED: begin
                        if (trig_evt) begin
                            state <= ST_REQ;
                        end
                    end
                    ST_REQ: begin
                        o_conv_start <= 1'b1;
                        o_conv_channel <= {cur_group, cur_pin};
                        state <= ST_WAIT;
                    end
                    ST_WAIT: begin
                        if (retrig) begin
                            step <= 4'h0;
                            rr_pin <= prio_n[2:0];
                            state <= ST_REQ;
                        end else if (accept) begin
                            if (mode == MODE_RS1) begin
                                if (prio_end) begin
                                    step <= 4'h0;
                                    rr_pin <= (rr_pin == PIN_LAST) ? prio_n[2:0] : rr_pin + 3'h1;
                                end else begin
                                    step <= step + 4'h1;
                                end
                                state <= ST_REQ;
                            end else if (last_step) begin
                                step <= 4'h0;
                                // a single sweep on external or hardware trigger waits for the next trigger
                                state <= mode_single ? ST_ARMED : ST_REQ;
                            end else begin
                                step <= step + 4'h1;
                                state <= ST_REQ;
                            end
                        end
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // results, strobes and requests
    logic [9:0] result_mem [NUM_SLOTS];
    logic [9:0] next_result;
    logic next_irq;
    // 8-bit codes come from the converter in the low byte
    assign next_result = res_10bit ? i_conv_data : {2'b00, i_conv_data[7:0]};

    always_comb begin
        next_irq = dma_mode_use;
        if (mode_mp) begin
            next_irq = 1'b1;
        end else if (mode == MODE_SS) begin
            next_irq = dma_mode_use || last_step;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_done_strobe <= 1'b0;
            o_irq <= 1'b0;
            o_dma_req <= 1'b0;
            o_result <= SLOT_RESET;
            o_conv_10bit <= 1'b0;
        end else begin
            o_conv_10bit <= res_10bit;
            o_done_strobe <= accept;
            o_irq <= accept && next_irq;
            o_dma_req <= accept && dma_mode_use;
            if (accept) begin
                o_result <= next_result;
            end
        end
    end

    for (genvar g = 0; g < NUM_SLOTS; g++) begin : g_slot
        always_ff @(posedge i_core_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                result_mem[g] <= SLOT_RESET;
            end else if (accept) begin
                if (dma_mode_use ? (g == 0) : (cur_pin == 3'(g))) begin
                    result_mem[g] <= next_result;
                end
            end
        end
    end

    assign o_result_slot_zero = result_mem[0];

    ////////////////////////////////////////////////////////////////////////////
    // read port; unmapped offsets read zero
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= 16'h0000;
        end else begin
            o_rdata <= 16'h0000;
            if (i_rd) begin
                if (i_addr == OFS_CTRL_0) begin
                    o_rdata <= {8'h00, conv_ctrl_0};
                end else if (i_addr == OFS_CTRL_1) begin
                    o_rdata <= {8'h00, conv_ctrl_1};
                end else if (i_addr == OFS_CTRL_2) begin
                    o_rdata <= {8'h00, conv_ctrl_2};
                end else if (i_addr == OFS_CTRL_3) begin
                    o_rdata <= {8'h00, conv_ctrl_3};
                end else if (i_addr == OFS_CTRL_4) begin
                    o_rdata <= {8'h00, conv_ctrl_4};
                end else if (i_addr == OFS_STATUS) begin
                    o_rdata <= {6'h00, state, step, 1'b0, cur_pin};
                end else if (i_addr >= OFS_SLOT_BASE && i_addr <= OFS_SLOT_LAST &&
                             i_addr[1:0] == 2'b00) begin
                    o_rdata <= {6'h00, result_mem[i_addr[4:2]]};
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    a_sw_start_go: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (state == ST_IDLE && conv_start_bit && mode_ok && !trigger_source_sel)
        |-> ##[1:2] (o_conv_start || !conv_start_bit))
        else $error("software start did not issue a conversion");
    a_armed_waits: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (state == ST_ARMED && !trig_evt) |=> (state != ST_REQ))
        else $error("conversion began without a trigger");
    a_repeat_holds: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (conv_start_bit && !mode_single && !wr_ctrl0) |=> conv_start_bit)
        else $error("start bit dropped in a repeat mode");
    a_rs_no_irq: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (o_irq && $past(mode == MODE_RS0 || mode == MODE_RS1)) |-> $past(dma_mode_use))
        else $error("repeat sweep raised an interrupt without dma mode");
    a_pin_slot: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (accept && !dma_mode_use) |=> (result_mem[$past(cur_pin)] == $past(next_result)))
        else $error("result not stored in its pin slot");
    a_dma_pairs: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        o_dma_req |-> (o_done_strobe && result_mem[0] == o_result))
        else $error("dma request without a slot zero result");
    a_rs1_no_retrig: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (state == ST_WAIT && mode == MODE_RS1 && trig_evt && !i_conv_done && conv_start_bit)
        |=> (state == ST_WAIT && $stable(step)))
        else $error("retrigger restarted repeat sweep 1");
    a_retrig_restart: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (retrig && conv_start_bit && mode_ok && !wr_ctrl0) |=> (step == 4'h0) ##1 o_conv_start)
        else $error("trigger during conversion did not restart");
    a_mp_order: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (state == ST_REQ && mode_mp && conv_start_bit)
        |=> (o_conv_channel == {($past(step) >= 4'h8) ? $past(multiport_sel) : FIRST_GROUP,
                                $past(step[2:0])}))
        else $error("multi-port order broken");
    a_single_stop: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (accept && last_step && mode_single && !trigger_source_sel && !wr_ctrl0)
        |=> !conv_start_bit ##1 (state == ST_IDLE))
        else $error("single sweep did not stop");
    // a stop written just before the last result sends the sequencer idle instead
    a_rs0_wrap: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (accept && last_step && mode == MODE_RS0 && conv_start_bit && !wr_ctrl0)
        |=> (step == 4'h0 && state == ST_REQ))
        else $error("repeat sweep 0 did not restart");
    a_mp_irq: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (accept && mode_mp) |=> (o_irq && o_done_strobe))
        else $error("multi-port conversion without interrupt");
    a_res_8bit: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (o_done_strobe && !$past(res_10bit)) |-> (o_result[9:8] == 2'b00))
        else $error("8-bit result has upper bits set");

endmodule : ass_sweep_sequencer

/* ass_conv_model.sv */
// converter core model standing at the far side of the sweep sequencer.
// assumes one start pulse at a time; answers LAT cycles later with a code.
module ass_conv_model #(
    parameter int LAT = 4
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_start,
    input wire logic [4:0] i_channel,
    output logic o_done,
    output logic [9:0] o_data
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    logic [4:0] ch;
    logic [9:0] last;
    ////////////////////////////////////////////////////////////////////////////
    // code carries its channel so the bench can tell results apart
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt <= 0;
            ch <= '0;
            last <= '0;
            o_done <= 1'b0;
            o_data <= '0;
        end else begin
            o_done <= 1'b0;
            // data is only valid with done; otherwise show the inverse
            o_data <= ~last;
            if (i_start) begin
                cnt <= LAT;
                ch <= i_channel;
            end else if (cnt == 1) begin
                o_done <= 1'b1;
                o_data <= {ch, 5'h15};
                last <= {ch, 5'h15};
                cnt <= 0;
            end else if (cnt > 1) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule : ass_conv_model

/* testbench.sv */
// testbench for the sweep sequencer: register tasks and mode scenarios.
// assumes ass_conv_model answers every start a few cycles later.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import ass_pkg::*;
    logic clk, rst_n, wr, rd, ext_n, mot, start, b10, done, dstb, irq, dreq;
    logic [7:0] addr;
    logic [15:0] wdata, rdata;
    logic [4:0] ch, lastch;
    logic [9:0] cdata, res, slot0, expv;
    logic dma_on = 1'b0;
    logic res10 = 1'b0;
    int failures = 0;
    int compares = 0;
    logic [4:0] chq[$];
    logic [4:0] expq[$];

    ass_sweep_sequencer uut (.i_core_clk(clk), .i_rst_n(rst_n), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .i_ext_trigger_in_n(ext_n), .i_motor_timer_count(mot), .o_conv_start(start),
        .o_conv_channel(ch), .o_conv_10bit(b10), .i_conv_done(done),
        .i_conv_data(cdata), .o_done_strobe(dstb), .o_irq(irq), .o_dma_req(dreq),
        .o_result(res), .o_result_slot_zero(slot0));
    ass_conv_model #(.LAT(4)) conv (.i_core_clk(clk), .i_rst_n(rst_n),
        .i_start(start), .i_channel(ch), .o_done(done), .o_data(cdata));

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input bit ok, input string m);
        compares++;
        if (!ok) begin
            failures++;
            $display("BAD %0t %s", $time, m);
        end
    endtask : chk

    task automatic tally_and_finish();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata === e, "read data");
    endtask : rd_reg

    // sampled at the falling edge so the monitor has pushed already
    task automatic waitn(input int n);
        for (int k = 0; k < 3000 && chq.size() < n; k++) @(negedge clk);
        if (chq.size() < n) chk(1'b0, "conversions missing");
    endtask : waitn

    task automatic cmp_seq();
        for (int i = 0; i < expq.size(); i++) chk(chq[i] === expq[i], "channel order");
    endtask : cmp_seq

    task automatic clr();
        chq.delete();
        expq.delete();
    endtask : clr

    task automatic stop(input logic [15:0] v);
        wr_reg(OFS_CTRL_0, v);
        repeat (8) @(posedge clk);
        chq.delete();
        repeat (20) @(posedge clk);
        chk(chq.size() == 0, "still converting");
    endtask : stop

    task automatic pulse(input bit motor);
        @(posedge clk);
        if (motor) mot <= 1'b1;
        else ext_n <= 1'b0;
        @(posedge clk);
        mot <= 1'b0;
        ext_n <= 1'b1;
    endtask : pulse

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk) begin
        if (start) begin
            chq.push_back(ch);
            lastch = ch;
            chk(b10 === res10, "resolution flag");
        end
        if (dstb) begin
            expv = res10 ? {lastch, 5'h15} : {2'b00, lastch[2:0], 5'h15};
            chk(res === expv, "result value");
            if (dma_on) chk(slot0 === expv, "slot zero");
            chk(irq === dma_on && dreq === dma_on, "request with strobe");
        end else if (irq || dreq) begin
            chk(1'b0, "stray request");
        end
    end

    initial begin
        #400us;
        failures++;
        tally_and_finish();
    end

    initial begin
        {wr, rd, mot, addr, wdata} = '0;
        ext_n = 1'b1;
        rst_n = 1'b0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        rd_reg(OFS_CTRL_0, 16'h0000);
        rd_reg(8'hfc, 16'h0000);
        wr_reg(OFS_SLOT_BASE, 16'h03ff);
        rd_reg(OFS_SLOT_BASE, 16'h0000);
        res10 = 1'b1;
        wr_reg(OFS_CTRL_1, 16'h0009);
        wr_reg(OFS_CTRL_0, 16'h000b);
        for (int i = 0; i < 8; i++) expq.push_back(5'(i % 4));
        waitn(9);
        rd_reg(OFS_CTRL_0, 16'h000b);
        cmp_seq();
        stop(16'h0003);
        for (int j = 0; j < 4; j++) rd_reg(8'(OFS_SLOT_BASE + 4 * j), {8'h00, 3'(j), 5'h15});
        // two pins of group 2, byte results through slot zero
        res10 = 1'b0;
        dma_on = 1'b1;
        wr_reg(OFS_CTRL_1, 16'h0000);
        wr_reg(OFS_CTRL_2, 16'h0002);
        wr_reg(OFS_CTRL_3, 16'h0001);
        clr();
        wr_reg(OFS_CTRL_0, 16'h000b);
        for (int i = 0; i < 4; i++) expq.push_back({2'b10, 3'(i % 2)});
        waitn(4);
        cmp_seq();
        stop(16'h0003);
        // single sweep over the same two pins ends by itself
        clr();
        wr_reg(OFS_CTRL_0, 16'h000a);
        for (int i = 0; i < 2; i++) expq.push_back({2'b10, 3'(i)});
        waitn(2);
        repeat (30) @(posedge clk);
        chk(chq.size() == 2, "single sweep length");
        cmp_seq();
        rd_reg(OFS_CTRL_0, 16'h0002);
        res10 = 1'b1;
        wr_reg(OFS_CTRL_2, 16'h0000);
        wr_reg(OFS_CTRL_3, 16'h0003);
        wr_reg(OFS_CTRL_4, 16'h0001);
        wr_reg(OFS_CTRL_1, 16'h0008);
        clr();
        wr_reg(OFS_CTRL_0, 16'h000a);
        for (int i = 0; i < 16; i++) expq.push_back(5'(i));
        waitn(16);
        repeat (30) @(posedge clk);
        chk(chq.size() == 16, "single pass length");
        cmp_seq();
        rd_reg(OFS_CTRL_0, 16'h0002);
        clr();
        wr_reg(OFS_CTRL_0, 16'h000b);
        for (int i = 0; i < 20; i++) expq.push_back(5'(i % 16));
        waitn(20);
        cmp_seq();
        stop(16'h0003);
        // prioritised sweep: a second trigger edge must not restart it
        dma_on = 1'b0;
        wr_reg(OFS_CTRL_3, 16'h0000);
        wr_reg(OFS_CTRL_4, 16'h0000);
        wr_reg(OFS_CTRL_1, 16'h000d);
        clr();
        wr_reg(OFS_CTRL_0, 16'h000f);
        repeat (10) @(posedge clk);
        chk(chq.size() == 0, "start without edge");
        pulse(1'b0);
        waitn(4);
        pulse(1'b0);
        for (int k = 0; k < 12; k++) expq.push_back(5'((k % 3 < 2) ? k % 3 : 2 + (k / 3) % 6));
        waitn(12);
        cmp_seq();
        stop(16'h0007);
        wr_reg(OFS_CTRL_1, 16'h0008);
        wr_reg(OFS_CTRL_2, 16'h0004);
        clr();
        wr_reg(OFS_CTRL_0, 16'h000f);
        repeat (10) @(posedge clk);
        chk(chq.size() == 0, "start without timer");
        pulse(1'b1);
        waitn(3);
        pulse(1'b1);
        waitn(5);
        expq = '{5'd0, 5'd1, 5'd0, 5'd0, 5'd1};
        cmp_seq();
        stop(16'h0007);
        tally_and_finish();
    end
endmodule : testbench
